// ### dpr_pkg.sv
// constants for the periodic-entry / reserved command decoder
// assumes frames arrive already deserialised and crc-checked upstream
package dpr_pkg;
  localparam logic [3:0] CMD_ENTER_PERIODIC = 4'hB;
  localparam logic [3:0] CMD_REG_READ = 4'h0;
  localparam logic [3:0] CMD_REG_WRITE = 4'h8;
  localparam logic [3:0] GLOBAL_ADDRESS = 4'h0;
  localparam logic [15:0] ENTER_DATA_VALUE = 16'h0000;
  // frame field positions inside the 24-bit payload
  localparam int ADDR_MSB = 23;
  localparam int ADDR_LSB = 20;
  localparam int CMD_MSB = 19;
  localparam int CMD_LSB = 16;
  // crc: polynomial x^8+x^4+x^3+x^2+1, seed all ones
  localparam logic [7:0] CRC_POLY = 8'h1D;
  localparam logic [7:0] CRC_SEED = 8'hFF;
  localparam int PAYLOAD_BITS = 24;
  // reset values
  localparam logic INIT_END_RESET = 1'b0;
  localparam logic [23:0] RESP_WORD_RESET = 24'h000000;
  localparam logic [7:0] RESP_CRC_RESET = 8'h00;
endpackage

// ### dpr_crc_if.sv
// carries the response payload to the crc unit and its crc back
// assumes both ends share one clock domain
`timescale 1ns/1ps
interface dpr_crc_if;
  logic [23:0] data;
  logic [7:0] crc;
  modport src (output data, input crc);
  modport calc (input data, output crc);
endinterface

// ### dpr_crc8.sv
// combinational crc-8 over the 24-bit response payload, msb first
// assumes the caller registers the result
`timescale 1ns/1ps
module dpr_crc8 (
  // payload in, crc out
  dpr_crc_if.calc crc_if
);
  logic [7:0] stage [0:dpr_pkg::PAYLOAD_BITS];

  assign stage[0] = dpr_pkg::CRC_SEED;

  genvar i;
  generate
    for (i = 0; i < dpr_pkg::PAYLOAD_BITS; i++) begin : g_bit
      logic fb;
      assign fb = stage[i][7] ^ crc_if.data[dpr_pkg::PAYLOAD_BITS - 1 - i];
      assign stage[i + 1] = {stage[i][6:0], 1'b0} ^ (fb ? dpr_pkg::CRC_POLY : 8'h00);
    end
  endgenerate

  assign crc_if.crc = stage[dpr_pkg::PAYLOAD_BITS];
endmodule

// ### dpr_cmd_decoder.sv
// periodic-entry and reserved-command decoder of the sensor slave interface
// assumes one frame_valid_i pulse per received frame, crc verdict alongside
//
// Behaviour
// - nibble 1011 with zero data is the enter-periodic-mode request.
// - own nonzero address match sets init-end, enters periodic mode, sends response.
// - global address 0000 sets init-end and enters periodic mode, no response.
// - enter request to any other address is silently dropped.
// - before entry only command mode; after entry periodic, diagnostics if enabled.
// - init-end locks configuration writes and enables user array verification.
// - init-end stays set until device reset; nothing else clears it.
// - addressed response: own address, 1011, chip time in bits 11:8, crc.
// - reserved code answered only on own address with valid crc.
// - reserved response echoes address and command, with correct crc.
// - reserved response data is free; received data bits ignored.
// - reserved code on foreign address gets no answer.
`timescale 1ns/1ps
module dpr_cmd_decoder (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // received frame
  input wire logic frame_valid_i,
  input wire logic [3:0] frame_address_field_i,
  input wire logic [3:0] frame_cmd_i,
  input wire logic [15:0] frame_data_i,
  input wire logic frame_crc_ok_i,
  // configuration
  input wire logic [3:0] phys_address_register_i,
  input wire logic [3:0] chip_time_value_i,
  input wire logic diag_background_enable_i,
  // mode and lock status
  output logic init_end_flag_o,
  output logic cmd_resp_mode_o,
  output logic periodic_collection_mode_o,
  output logic diag_background_mode_o,
  output logic config_write_block_o,
  output logic user_array_verify_en_o,
  // response frame
  output logic resp_valid_o,
  output logic [23:0] resp_word_o,
  output logic [7:0] resp_crc_o
);

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops; assertion stays asynchronous
  logic rst_meta_q;
  logic rst_meta_d;
  logic rst_sync_q;
  logic rst_sync_d;

  always_comb begin
    rst_meta_d = 1'b1;
    rst_sync_d = rst_meta_q;
  end

  // only the second flop feeds the rest of the block
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= rst_meta_d;
      rst_sync_q <= rst_sync_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state and decode signals
  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_ENTER_GLOBAL,
    ACT_ENTER_OWN,
    ACT_RESERVED_ECHO
  } dpr_action_t;

  logic init_end_q;
  logic init_end_d;
  logic resp_valid_q;
  logic resp_valid_d;
  logic [23:0] resp_word_q;
  logic [23:0] resp_word_d;
  logic [23:0] resp_word_new;
  logic [7:0] resp_crc_q;
  logic [7:0] resp_crc_d;
  logic own_addr;
  logic global_addr;
  logic data_zero;
  logic cmd_is_enter;
  logic cmd_is_reserved;
  logic take;
  dpr_action_t action;

  ////////////////////////////////////////////////////////////////////////
  // address and command classification
  assign own_addr = frame_address_field_i == phys_address_register_i;
  assign global_addr = frame_address_field_i == dpr_pkg::GLOBAL_ADDRESS;
  // an entry request with any data bit set is malformed, not an entry
  assign data_zero = frame_data_i == dpr_pkg::ENTER_DATA_VALUE;

  // read and write codes belong to the register access path
  always_comb begin
    cmd_is_enter = 1'b0;
    cmd_is_reserved = 1'b0;
    case (frame_cmd_i)
      dpr_pkg::CMD_ENTER_PERIODIC: begin
        cmd_is_enter = data_zero;
      end
      dpr_pkg::CMD_REG_READ,
      dpr_pkg::CMD_REG_WRITE: begin
        cmd_is_enter = 1'b0;
        cmd_is_reserved = 1'b0;
      end
      default: begin
        // data bits of a reserved code are not looked at
        cmd_is_reserved = 1'b1;
      end
    endcase
  end

  // command mode only listens before entry; bad crc frames never act
  assign take = frame_valid_i && frame_crc_ok_i && !init_end_q;

  ////////////////////////////////////////////////////////////////////////
  // action select; global entry wins, so an entry to own address zero stays silent
  always_comb begin
    action = ACT_NONE;
    if (take && cmd_is_enter && global_addr) begin
      action = ACT_ENTER_GLOBAL;
    end else if (take && cmd_is_enter && own_addr) begin
      action = ACT_ENTER_OWN;
    end else if (take && cmd_is_reserved && own_addr) begin
      action = ACT_RESERVED_ECHO;
    end else begin
      // foreign addresses and refused frames leave no trace
      action = ACT_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // init-end flag: set only, cleared by reset alone
  always_comb begin
    init_end_d = init_end_q;
    case (action)
      ACT_ENTER_GLOBAL: begin
        init_end_d = 1'b1;
      end
      ACT_ENTER_OWN: begin
        init_end_d = 1'b1;
      end
      default: begin
        init_end_d = init_end_q;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      init_end_q <= dpr_pkg::INIT_END_RESET;
    end else begin
      init_end_q <= init_end_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // response word, built ahead of the crc unit
  always_comb begin
    resp_word_new = resp_word_q;
    case (action)
      ACT_ENTER_OWN: begin
        resp_word_new = {phys_address_register_i, dpr_pkg::CMD_ENTER_PERIODIC,
                         4'h0, chip_time_value_i, 8'h00};
      end
      ACT_RESERVED_ECHO: begin
        // data field is free; zero keeps the echo deterministic
        resp_word_new = {frame_address_field_i, frame_cmd_i, 16'h0000};
      end
      default: begin
        resp_word_new = resp_word_q;
      end
    endcase
  end

  // crc over the word being loaded, so word and crc stand together
  dpr_crc_if crc_bus ();

  assign crc_bus.data = resp_word_new;

  dpr_crc8 u_crc (
    .crc_if (crc_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // response group: one pulse per answered frame, word and crc held
  always_comb begin
    resp_valid_d = 1'b0;
    resp_word_d = resp_word_q;
    resp_crc_d = resp_crc_q;
    if (action == ACT_ENTER_OWN || action == ACT_RESERVED_ECHO) begin
      resp_valid_d = 1'b1;
      resp_word_d = resp_word_new;
      resp_crc_d = crc_bus.crc;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      resp_valid_q <= 1'b0;
      resp_word_q <= dpr_pkg::RESP_WORD_RESET;
      resp_crc_q <= dpr_pkg::RESP_CRC_RESET;
    end else begin
      resp_valid_q <= resp_valid_d;
      resp_word_q <= resp_word_d;
      resp_crc_q <= resp_crc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode and lock outputs; all follow the one sticky flag
  assign init_end_flag_o = init_end_q;
  // command mode is on exactly while periodic mode is off
  assign periodic_collection_mode_o = init_end_q;
  assign cmd_resp_mode_o = !init_end_q;
  // enable bit has no effect before entry
  assign diag_background_mode_o = init_end_q && diag_background_enable_i;
  assign config_write_block_o = init_end_q;
  assign user_array_verify_en_o = init_end_q;

  ////////////////////////////////////////////////////////////////////////
  // response outputs
  assign resp_valid_o = resp_valid_q;
  assign resp_word_o = resp_word_q;
  assign resp_crc_o = resp_crc_q;

endmodule

// ### dpr_cmd_sva.sv
// port checker for the command decoder
// assumes frames only after the internal reset copy is released
`timescale 1ns/1ps
module dpr_cmd_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // received frame
  input wire logic frame_valid_i,
  input wire logic frame_crc_ok_i,
  input wire logic [3:0] frame_address_field_i,
  input wire logic [3:0] frame_cmd_i,
  input wire logic [15:0] frame_data_i,
  // configuration
  input wire logic [3:0] phys_address_register_i,
  input wire logic [3:0] chip_time_value_i,
  input wire logic diag_background_enable_i,
  // watched outputs
  input wire logic init_end_flag_o,
  input wire logic cmd_resp_mode_o,
  input wire logic periodic_collection_mode_o,
  input wire logic diag_background_mode_o,
  input wire logic config_write_block_o,
  input wire logic user_array_verify_en_o,
  input wire logic resp_valid_o,
  input wire logic [23:0] resp_word_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic go, own, hit, rsv, ent, adr0;
  assign go = frame_valid_i && frame_crc_ok_i && !init_end_flag_o;
  assign adr0 = frame_address_field_i == 4'h0;
  // reserved codes to address zero are answered when zero is the own address
  assign hit = frame_address_field_i == phys_address_register_i;
  assign own = hit && !adr0;
  assign rsv = !(frame_cmd_i inside {4'h0, 4'h8, 4'hB});
  assign ent = go && frame_cmd_i == 4'hB && frame_data_i == 16'h0000;
  chk_mode_split: assert property (
    cmd_resp_mode_o != periodic_collection_mode_o && periodic_collection_mode_o == init_end_flag_o)
    else $error("mode outputs disagree");
  chk_diag_gate: assert property (
    diag_background_mode_o == (init_end_flag_o && diag_background_enable_i))
    else $error("diagnostic mode wrong");
  chk_lock_follow: assert property (
    {config_write_block_o, user_array_verify_en_o} == {2{init_end_flag_o}})
    else $error("lock outputs wrong");
  chk_flag_sticky: assert property (init_end_flag_o |=> init_end_flag_o)
    else $error("init end flag cleared");
  chk_enter_own: assert property (ent && own |=> resp_valid_o && init_end_flag_o &&
    resp_word_o == {$past(frame_address_field_i), 8'hB0, $past(chip_time_value_i), 8'h00})
    else $error("addressed entry wrong");
  chk_enter_glob: assert property (ent && adr0 |=> init_end_flag_o && !resp_valid_o)
    else $error("global entry wrong");
  chk_enter_drop: assert property (ent && !adr0 && !own |=> !init_end_flag_o && !resp_valid_o)
    else $error("foreign entry taken");
  chk_rsv_echo: assert property (go && rsv && hit |=> resp_valid_o &&
    resp_word_o[23:16] == {$past(frame_address_field_i), $past(frame_cmd_i)})
    else $error("reserved echo wrong");
  chk_rsv_quiet: assert property (frame_valid_i && rsv && !(go && hit) |=> !resp_valid_o)
    else $error("reserved answered");
  cover property (ent && own);
  cover property (ent && adr0);
  cover property (go && rsv && hit);
endmodule
bind dpr_cmd_decoder dpr_cmd_sva dpr_cmd_sva_i (.*);

// ### dpr_master_model.sv
// bus master model: one decoded frame per send call
// assumes calls come from one process
`timescale 1ns/1ps
module dpr_master_model (
  // clock
  input wire logic clk_i,
  // decoded frame towards the decoder
  output logic fv_o,
  output logic ok_o,
  output logic [3:0] fa_o,
  output logic [3:0] fc_o,
  output logic [15:0] fd_o
);
  initial {fv_o, ok_o, fa_o, fc_o, fd_o} = '0;
  task automatic send(input logic [3:0] a, c, input logic [15:0] d, input logic ok);
    @(negedge clk_i);
    {fv_o, ok_o, fa_o, fc_o, fd_o} = {1'b1, ok, a, c, d};
    @(negedge clk_i);
    // released lines invert so stale values never match
    {fv_o, ok_o, fa_o, fc_o, fd_o} = {1'b0, ~ok, ~a, ~c, ~d};
  endtask
  task automatic enter(input logic [3:0] a);
    send(a, dpr_pkg::CMD_ENTER_PERIODIC, 16'h0000, 1'b1);
  endtask
endmodule

// ### dsi3_periodic_collection_mode_entry_reserved_cmd_tb.sv
// testbench for the periodic-entry and reserved command decoder
// assumes the master model drives frames at falling edges
`timescale 1ns/1ps
module dsi3_periodic_collection_mode_entry_reserved_cmd_tb;
  logic clk_i = 0, rst_b_i = 0, dg = 1, fv, ok, in, cm, pm, dm, bk, ve, rv;
  logic [3:0] ph = 4'h5, ch = 4'hA, fa, fc;
  logic [15:0] fd;
  logic [23:0] rw;
  logic [7:0] rc;
  // {crc_ok, address, command, data}; none of these may be answered or taken
  logic [24:0] bad [8] = '{25'h0530000, 25'h1033000, 25'h1003000, 25'h15B0001,
    25'h16B0000, 25'h1630000, 25'h1580000, 25'h05B0000};
  int failures = 0, checks_done = 0;
  initial forever #25 clk_i = ~clk_i;
  dpr_master_model dpr_master_model_i (.clk_i, .fv_o(fv), .ok_o(ok), .fa_o(fa), .fc_o(fc),
    .fd_o(fd));
  dpr_cmd_decoder dpr_cmd_decoder_i (.clk_i, .rst_b_i, .frame_valid_i(fv),
    .frame_address_field_i(fa), .frame_cmd_i(fc), .frame_data_i(fd), .frame_crc_ok_i(ok),
    .phys_address_register_i(ph), .chip_time_value_i(ch), .diag_background_enable_i(dg),
    .init_end_flag_o(in), .cmd_resp_mode_o(cm), .periodic_collection_mode_o(pm),
    .diag_background_mode_o(dm), .config_write_block_o(bk), .user_array_verify_en_o(ve),
    .resp_valid_o(rv), .resp_word_o(rw), .resp_crc_o(rc));
  function automatic logic [7:0] crc8(input logic [23:0] w);
    logic [7:0] c;
    c = dpr_pkg::CRC_SEED;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? dpr_pkg::CRC_POLY : 8'h00);
    return c;
  endfunction
  task chk(input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task resp(input logic [23:0] w);
    chk(rv, 1);
    chk({rw, rc}, {w, crc8(w)});
  endtask
  task rst_dut;
    rst_b_i = 0;
    repeat (16) @(negedge clk_i);
    rst_b_i = 1;
    repeat (4) @(negedge clk_i);
  endtask
  task summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #50us;
    failures++;
    summarize();
  end
  initial begin
    rst_dut();
    for (int i = 0; i < 8; i++) begin
      dpr_master_model_i.send(bad[i][23:20], bad[i][19:16], bad[i][15:0], bad[i][24]);
      chk({rv, in, cm, pm, dm, bk, ve}, 7'b0010000);
    end
    for (int c = 1; c < 16; c++) if (!(c inside {8, 11})) begin
      dpr_master_model_i.send(ph, c[3:0], 16'hFFFF, 1'b1);
      resp({ph, c[3:0], 16'h0000});
    end
    dpr_master_model_i.enter(ph);
    resp({ph, 8'hB0, ch, 8'h00});
    chk({in, pm, cm, dm, bk, ve}, 6'b110111);
    dg = 0;
    #1 chk(dm, 0);
    dpr_master_model_i.send(ph, 4'h3, 16'h0000, 1'b1);
    chk({rv, in}, 2'b01);
    rst_dut();
    chk(in, 0);
    dpr_master_model_i.enter(4'h0);
    chk({rv, in, pm}, 3'b011);
    ph = 4'h0;
    rst_dut();
    chk(in, 0);
    dpr_master_model_i.send(4'h0, 4'h3, 16'h0000, 1'b1);
    resp({4'h0, 4'h3, 16'h0000});
    dpr_master_model_i.enter(4'h0);
    chk({rv, in}, 2'b01);
    summarize();
  end
endmodule
